// ===== hdl/aps_edge.sv
`default_nettype none

module aps_edge #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_clk_en,
  // Pin and edge choice
  input  wire logic i_sig,
  input  wire logic i_falling,
  // Detected edge
  output logic      o_edge
);

  logic prev_reg;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_reg <= RESET_LEVEL;
    end else if (i_clk_en) begin
      prev_reg <= i_sig;
    end
  end

  assign o_edge = i_falling ? (prev_reg & ~i_sig) : (~prev_reg & i_sig);

endmodule

`default_nettype wire

// ===== hdl/aps_pkg.sv
`default_nettype none

package aps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one pacing tick per two master-clock periods (5 MHz tick rate)
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 200;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Queue and channel addressing
  localparam int QUEUE_DEPTH    = 256;
  localparam int QUEUE_DEPTH_HC = 64;
  localparam int QIDX_W         = 8;
  localparam logic [QIDX_W-1:0] Q_LAST_HC = QIDX_W'(QUEUE_DEPTH_HC - 1);
  localparam int LCHAN_W        = 9;
  localparam int SEL_W          = 4;
  localparam logic [LCHAN_W-1:0] LCHAN_EXP_BASE = 9'h010;
  localparam int GAIN_W         = 2;
  localparam int DIN_W          = 4;
  localparam int DIN_PACER_BIT  = 0;
  localparam int DIN_TRIG_BIT   = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Combined sample-count word and pacing counters
  localparam int SWORD_W       = 32;
  localparam int REPEAT_EN_BIT = 31;
  localparam int REP_CNT_LSB   = 16;
  localparam int REP_CNT_W     = 12;
  localparam int BURST_CNT_LSB = 0;
  localparam int BURST_CNT_W   = 16;
  localparam int PERIOD_W      = 24;
  localparam int INTRA_W       = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and states
  typedef enum logic [1:0] {
    PACE_RATE   = 2'h0,
    PACE_BURST  = 2'h1,
    PACE_EXTCLK = 2'h2
  } aps_pace_t;

  // Codes follow the start-condition channel numbers
  typedef enum logic [1:0] {
    TRIG_DIGITAL = 2'h0,
    TRIG_COMMAND = 2'h1,
    TRIG_EXTERN  = 2'h2
  } aps_trig_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN   = 2'b11
  } aps_state_t;

  typedef struct packed {
    aps_pace_t            pace_mode;
    logic                 ext_clk_falling;
    logic                 gated;
    aps_trig_t            trig_src;
    logic                 trig_falling;
    logic                 trig_on_mismatch;
    logic [DIN_W-1:0]     trig_mask;
    logic [DIN_W-1:0]     trig_pattern;
    logic [PERIOD_W-1:0]  period;
    logic [INTRA_W-1:0]   intra_burst_interval;
    logic [SWORD_W-1:0]   sample_word;
    logic [QIDX_W-1:0]    q_last;
    logic                 hc_variant;
  } aps_cfg_t;

  typedef struct packed {
    logic [GAIN_W-1:0]  gain;
    logic [LCHAN_W-1:0] lchan;
  } aps_qent_t;

  typedef struct packed {
    logic [SEL_W-1:0]  native;
    logic [SEL_W-1:0]  mux_sel;
    logic [GAIN_W-1:0] gain;
  } aps_conv_t;

endpackage

`default_nettype wire

// ===== hdl/aps_top.sv
// Contract
// R1: Init aborts any running acquisition and halts the pacing clock.
// R2: Pacing time counts in 200 ns ticks from the 5 MHz master clock; the code divides a 10 MHz (100 ns) clock by 2.
// R3: Burst mode starts bursts separated by a programmed period in ticks.
// R4: Conversions in a burst are spaced by the intra-burst interval in ticks.
// R5: Sample count sets conversions per burst; software matches it to scanned channels.
// R6: Software keeps intra-burst interval within 30 to 320 ticks (20 us high-res).
// R7: Burst pacing works with every transfer type; too fast loses samples.
// R8: Repeat sampling converts one queue entry 1 to 4095 times before advancing.
// R9: Sample word MSB enables repeat; upper half-word holds repeat count.
// R10: With repeat, lower half-word holds samples per burst.
// R11: External pacing clock converts on a selectable rising or falling edge.
// R12: High-channel variant takes pacing clock from digital input bit 0.
// R13: Start comes from 4-bit digital port or external trigger input.
// R14: Digital start: input AND mask compared to pattern, match or mismatch.
// R15: Hardware start fires on selectable edge of external trigger input.
// R16: Gated mode paces only while trigger/gate input is high.
// R17: Intra-burst interval zero gives back-to-back simultaneous sampling.
// R18: Device drives expansion mux select lines itself, per sample.
// R19: Each expansion mux routes one of 16 inputs onto its native channel.
// R20: Logical 0-15 native; 16-271 expansion as (native+1)*16+input.
// R21: Native channel with mux attached selects mux input 0.
// R22: Queue holds 256 entries, 64 on high-channel variant.
// R23: Data overrun sets a visible flag and stops acquisition.
// R24: After the last queue entry the sequencer wraps to the first.
`default_nettype none

module aps_top import aps_pkg::*; (
  // Clock, reset, enable
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  input  wire logic              i_clk_en,
  // Control and configuration
  input  wire logic              i_init,
  input  wire logic              i_start,
  input  wire logic              i_stop,
  input  wire aps_cfg_t          i_cfg,
  // Channel/gain queue load
  input  wire logic              i_q_we,
  input  wire logic [QIDX_W-1:0] i_q_addr,
  input  wire aps_qent_t         i_q_data,
  // External pins
  input  wire logic              i_ext_pacer_clk_in,
  input  wire logic              i_ext_trig_gate_in,
  input  wire logic [DIN_W-1:0]  i_din,
  // Converter handshake
  input  wire logic              i_conv_done,
  input  wire logic              i_data_read,
  // Converter and status outputs
  output var aps_conv_t          o_conv,
  output var logic               o_conv_start,
  output var logic               o_running,
  output var logic               o_armed,
  output var logic               o_overrun,
  output var logic [QIDX_W-1:0]  o_queue_idx
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  aps_state_t                state_reg;
  aps_state_t                state_next;
  logic [TICK_W-1:0]         tick_cnt_reg;
  logic [PERIOD_W-1:0]       period_cnt_reg;
  logic [INTRA_W-1:0]        intra_cnt_reg;
  logic [BURST_CNT_W-1:0]    burst_left_reg;
  logic [REP_CNT_W-1:0]      rep_cnt_reg;
  logic [QIDX_W-1:0]         idx_reg;
  logic                      pend_reg;
  aps_qent_t                 queue_mem [QUEUE_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Pin selection and edges

  wire logic pacer_pin = i_cfg.hc_variant ? i_din[DIN_PACER_BIT] : i_ext_pacer_clk_in;  // R12
  wire logic trig_pin  = i_cfg.hc_variant ? i_din[DIN_TRIG_BIT] : i_ext_trig_gate_in;
  logic      pacer_edge;
  logic      trig_edge;

  aps_edge u_pacer_edge (
    .i_clock   (i_clock),
    .i_rstn    (i_rstn),
    .i_clk_en  (i_clk_en),
    .i_sig     (pacer_pin),
    .i_falling (i_cfg.ext_clk_falling),
    .o_edge    (pacer_edge)
  );

  aps_edge u_trig_edge (
    .i_clock   (i_clock),
    .i_rstn    (i_rstn),
    .i_clk_en  (i_clk_en),
    .i_sig     (trig_pin),
    .i_falling (i_cfg.trig_falling),
    .o_edge    (trig_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start condition

  wire logic running   = (state_reg == ST_RUN);
  wire logic armed     = (state_reg == ST_ARMED);
  wire logic dig_equal = ((i_din & i_cfg.trig_mask) == i_cfg.trig_pattern);
  wire logic dig_match = dig_equal ^ i_cfg.trig_on_mismatch;  // R14
  logic      start_cond;

  always_comb begin
    unique case (i_cfg.trig_src)  // R13
      TRIG_DIGITAL: start_cond = dig_match;
      TRIG_EXTERN:  start_cond = trig_edge;  // R15
      TRIG_COMMAND: start_cond = 1'b1;
      default:      start_cond = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pacing

  wire logic [BURST_CNT_W-1:0] burst_samples = i_cfg.sample_word[BURST_CNT_LSB +: BURST_CNT_W];  // R10
  wire logic                   rep_en        = i_cfg.sample_word[REPEAT_EN_BIT];  // R9
  wire logic [REP_CNT_W-1:0]   rep_total     = i_cfg.sample_word[REP_CNT_LSB +: REP_CNT_W];  // R9

  wire logic tick        = (tick_cnt_reg == TICK_LAST);  // R2
  wire logic gate_ok     = ~i_cfg.gated | trig_pin;  // R16
  wire logic adv         = running & gate_ok;
  wire logic period_hit  = adv & tick & (period_cnt_reg == '0);
  wire logic mode_rate   = (i_cfg.pace_mode == PACE_RATE);
  wire logic mode_burst  = (i_cfg.pace_mode == PACE_BURST);
  wire logic mode_ext    = (i_cfg.pace_mode == PACE_EXTCLK);
  wire logic burst_start = mode_burst & period_hit;  // R3
  // Interval zero fires on consecutive cycles for track-and-hold use
  wire logic burst_fire  = mode_burst & adv & (burst_left_reg != '0) & (intra_cnt_reg == '0);  // R4 R17
  wire logic fire        = (mode_rate & period_hit) | burst_fire | (mode_ext & adv & pacer_edge);  // R11 R7

  wire logic [PERIOD_W-1:0] period_reload =
    (i_cfg.period == '0) ? '0 : PERIOD_W'(i_cfg.period - 24'h00_0001);

  ////////////////////////////////////////////////////////////////////////////
  // Queue sequencing

  wire logic [QIDX_W-1:0] q_last_eff =
    (i_cfg.hc_variant && (i_cfg.q_last > Q_LAST_HC)) ? Q_LAST_HC : i_cfg.q_last;  // R22
  wire logic [REP_CNT_W:0] rep_plus = {1'b0, rep_cnt_reg} + 13'h0001;
  // A repeat count of zero behaves as one
  wire logic last_rep = ~rep_en | (rep_plus >= {1'b0, rep_total});  // R8
  wire logic advance  = fire & last_rep;
  wire logic [QIDX_W-1:0] idx_wrap = (idx_reg == q_last_eff) ? '0 : QIDX_W'(idx_reg + 8'h01);  // R24

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode for native inputs and expansion muxes

  aps_qent_t        cur_ent;
  assign cur_ent = queue_mem[idx_reg];
  wire logic        is_native = (cur_ent.lchan < LCHAN_EXP_BASE);  // R20
  wire logic [LCHAN_W-1:0] exp_off = LCHAN_W'(cur_ent.lchan - LCHAN_EXP_BASE);
  aps_conv_t        conv_next;
  // Mux input 0 shares the native channel's logical number
  assign conv_next.native  = is_native ? cur_ent.lchan[SEL_W-1:0] : exp_off[2*SEL_W-1:SEL_W];  // R20 R19
  assign conv_next.mux_sel = is_native ? '0 : exp_off[SEL_W-1:0];  // R21 R18
  assign conv_next.gain    = cur_ent.gain;

  ////////////////////////////////////////////////////////////////////////////
  // Overrun: a new result arrives before the last one was read

  wire logic overrun_set = running & i_conv_done & pend_reg & ~i_data_read;  // R23 R7

  ////////////////////////////////////////////////////////////////////////////
  // Control state machine

  always_comb begin
    state_next = state_reg;
    if (i_init || i_stop) begin
      state_next = ST_IDLE;  // R1
    end else begin
      unique case (state_reg)
        ST_IDLE:  if (i_start && !o_overrun) state_next = ST_ARMED;
        ST_ARMED: if (start_cond) state_next = ST_RUN;
        ST_RUN:   if (overrun_set) state_next = ST_IDLE;  // R23
        default:  state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      o_running <= 1'b0;
      o_armed   <= 1'b0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      o_running <= (state_next == ST_RUN);
      o_armed   <= (state_next == ST_ARMED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider and pacing counters; all cleared while not running

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_reg   <= '0;
      period_cnt_reg <= '0;
    end else if (i_clk_en) begin
      if (!running || i_init || i_stop) begin
        tick_cnt_reg   <= '0;  // R1
        period_cnt_reg <= '0;
      end else if (gate_ok) begin
        tick_cnt_reg <= tick ? '0 : TICK_W'(tick_cnt_reg + 1'b1);  // R2
        if (tick) begin
          period_cnt_reg <= (period_cnt_reg == '0) ? period_reload : PERIOD_W'(period_cnt_reg - 1'b1);  // R3
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      intra_cnt_reg  <= '0;
      burst_left_reg <= '0;
    end else if (i_clk_en) begin
      if (!running || burst_start) begin
        intra_cnt_reg  <= '0;
        burst_left_reg <= running ? burst_samples : '0;  // R5
      end else if (burst_fire) begin
        intra_cnt_reg  <= i_cfg.intra_burst_interval;  // R4
        burst_left_reg <= BURST_CNT_W'(burst_left_reg - 1'b1);  // R5
      end else if (adv && tick && intra_cnt_reg != '0) begin
        intra_cnt_reg <= INTRA_W'(intra_cnt_reg - 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue position and repeat counter

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      idx_reg     <= '0;
      rep_cnt_reg <= '0;
    end else if (i_clk_en) begin
      if (state_reg != ST_RUN) begin
        idx_reg     <= '0;
        rep_cnt_reg <= '0;
      end else if (fire) begin
        rep_cnt_reg <= last_rep ? '0 : rep_plus[REP_CNT_W-1:0];  // R8
        if (advance) begin
          idx_reg <= idx_wrap;  // R24
        end
      end
    end
  end

  assign o_queue_idx = idx_reg;

  // Queue contents survive reset; software loads them before starting
  always_ff @(posedge i_clock) begin
    if (i_clk_en && i_q_we) begin
      queue_mem[i_q_addr] <= i_q_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter outputs, pending data and overrun flag

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_conv_start <= 1'b0;
      o_conv       <= '0;
      pend_reg     <= 1'b0;
      o_overrun    <= 1'b0;
    end else if (i_clk_en) begin
      o_conv_start <= fire;  // R18
      if (fire) begin
        o_conv <= conv_next;  // R18
      end
      // New result wins over a read in the same cycle
      pend_reg  <= i_init ? 1'b0 : (i_conv_done | (pend_reg & ~i_data_read));
      o_overrun <= overrun_set | (o_overrun & ~i_init);  // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_burst_begin;
    burst_start && i_clk_en;
  endsequence

  sequence s_first_fire;
    i_clk_en && burst_fire;
  endsequence

  chk_init_halts: assert property (i_init && i_clk_en |=> !o_running && !o_armed && tick_cnt_reg == '0)  // R1
    else $error("init did not halt acquisition");

  chk_tick_period: assert property (tick && i_clk_en && running && gate_ok ##1 i_clk_en |-> !tick)  // R2
    else $error("tick came on adjacent cycles");

  chk_burst_load: assert property (s_burst_begin |=> burst_left_reg == $past(burst_samples))  // R5
    else $error("burst count not loaded");

  chk_burst_first: assert property (s_burst_begin ##1 (i_clk_en && running && gate_ok
                                    && burst_left_reg != '0) |-> s_first_fire)  // R3
    else $error("burst did not start converting");

  chk_intra_space: assert property (burst_fire && i_clk_en && i_cfg.intra_burst_interval != '0
                                    |=> !burst_fire)  // R4
    else $error("burst conversions too close");

  chk_conv_follows: assert property (fire && i_clk_en |=> o_conv_start)  // R18
    else $error("conversion start missing");

  chk_exp_decode: assert property (fire && i_clk_en && !is_native
                                   |=> {o_conv.native, o_conv.mux_sel} == 8'($past(cur_ent.lchan) - 9'h010))  // R20
    else $error("expansion channel decode wrong");

  chk_native_mux0: assert property (fire && i_clk_en && is_native |=> o_conv.mux_sel == '0)  // R21
    else $error("native channel did not pick mux input 0");

  chk_overrun_stop: assert property (overrun_set && i_clk_en |=> o_overrun && !o_running)  // R23
    else $error("overrun did not stop acquisition");

  chk_queue_wrap: assert property (advance && i_clk_en && idx_reg == q_last_eff && !i_init && !i_stop
                                   && !overrun_set |=> idx_reg == '0)  // R24
    else $error("queue did not wrap");

  chk_repeat_hold: assert property (fire && i_clk_en && !last_rep |=> idx_reg == $past(idx_reg))  // R8
    else $error("queue advanced during repeat");

  chk_gate_pause: assert property (i_clk_en && running && i_cfg.gated && !trig_pin |=> !o_conv_start)  // R16
    else $error("conversion while gate low");

  chk_dig_start: assert property (i_clk_en && armed && i_cfg.trig_src == TRIG_DIGITAL && dig_match
                                  && !i_init && !i_stop |=> o_running)  // R14
    else $error("digital start missed");

endmodule

`default_nettype wire

// ===== verification/aps_conv_model.sv
`default_nettype none

module aps_conv_model (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rstn,
  // Behaviour select
  input  wire logic i_slow,
  input  wire logic i_read_en,
  // Converter side
  input  wire logic i_conv_start,
  output logic      o_conv_done,
  output logic      o_data_read
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] pipe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // One read per result; withholding reads is the only fault the bench asks for
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pipe_reg    <= 3'h0;
      o_data_read <= 1'b0;
    end else begin
      pipe_reg    <= {pipe_reg[1:0], i_conv_start};
      o_data_read <= o_conv_done & i_read_en;
    end
  end

  // Slow mode stretches a conversion to three cycles
  assign o_conv_done = i_slow ? pipe_reg[2] : pipe_reg[0];
endmodule

`default_nettype wire

// ===== verification/tb.sv
`default_nettype none

module tb;
  import aps_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic              i_clock;
  logic              i_rstn;
  logic              i_clk_en;
  logic              i_init;
  logic              i_start;
  logic              i_stop;
  aps_cfg_t          i_cfg;
  logic              i_q_we;
  logic [QIDX_W-1:0] i_q_addr;
  aps_qent_t         i_q_data;
  logic              i_ext_pacer_clk_in;
  logic              i_ext_trig_gate_in;
  logic [DIN_W-1:0]  i_din;
  logic              i_conv_done;
  logic              i_data_read;
  aps_conv_t         o_conv;
  logic              o_conv_start;
  logic              o_running;
  logic              o_armed;
  logic              o_overrun;
  logic [QIDX_W-1:0] o_queue_idx;
  logic              slow;
  logic              read_en;
  aps_qent_t         qtab [3];
  aps_cfg_t          base;
  int                err_count;
  int                n_tests;

  aps_top i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_init(i_init),
    .i_start(i_start), .i_stop(i_stop), .i_cfg(i_cfg), .i_q_we(i_q_we), .i_q_addr(i_q_addr),
    .i_q_data(i_q_data), .i_ext_pacer_clk_in(i_ext_pacer_clk_in), .i_ext_trig_gate_in(i_ext_trig_gate_in),
    .i_din(i_din), .i_conv_done(i_conv_done), .i_data_read(i_data_read), .o_conv(o_conv),
    .o_conv_start(o_conv_start), .o_running(o_running), .o_armed(o_armed), .o_overrun(o_overrun),
    .o_queue_idx(o_queue_idx));

  aps_conv_model i_conv (.i_clock(i_clock), .i_rstn(i_rstn), .i_slow(slow), .i_read_en(read_en),
    .i_conv_start(o_conv_start), .o_conv_done(i_conv_done), .o_data_read(i_data_read));

  always #50 i_clock = ~i_clock;

  ////////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #10;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic rst(input int n);
    i_rstn = 1'b0;
    step(n);
    i_rstn = 1'b1;
    step(1);
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
    rst(2);
  endtask

  // Lowering is followed by a full cycle so back-to-back calls never re-drive in one step
  task automatic ctl(input logic [2:0] v);
    {i_init, i_start, i_stop} = v;
    step(1);
    {i_init, i_start, i_stop} = 3'h0;
    step(1);
  endtask

  task automatic go(input aps_cfg_t c);
    i_cfg = c;
    ctl(3'h2);
  endtask

  // Bit 0 is the pacer pin, bit 1 the trigger pin; hc moves both onto the port
  task automatic pin(input int b, input logic hc, input logic lvl);
    i_din[b] = hc & lvl;
    if (b == 0) i_ext_pacer_clk_in = !hc & lvl;
    else i_ext_trig_gate_in = !hc & lvl;
  endtask

  task automatic count_conv(input int n, output int k);
    k = 0;
    repeat (n) begin
      step(1);
      if (o_conv_start === 1'b1) k++;
    end
  endtask

  task automatic wait_conv(output int g);
    g = 0;
    do begin
      step(1);
      g++;
    end while (o_conv_start !== 1'b1 && g < 600);
    if (o_conv_start !== 1'b1) begin
      check("o_conv_start", o_conv_start, 1'b1);
      tally_and_finish();
    end
  endtask

  function automatic aps_conv_t exp_conv(input aps_qent_t q);
    logic x;
    x = (q.lchan >= LCHAN_EXP_BASE);
    exp_conv.gain    = q.gain;
    exp_conv.native  = x ? 4'((q.lchan - LCHAN_EXP_BASE) >> 4) : q.lchan[3:0];
    exp_conv.mux_sel = x ? q.lchan[3:0] : 4'h0;
  endfunction

  task automatic conv_seq(input int ents[$], input int gaps[$]);
    int g;
    foreach (ents[i]) begin
      wait_conv(g);
      if (i > 0) check("conversion gap", g, gaps[i-1]);
      check("o_conv", o_conv, exp_conv(qtab[ents[i]]));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    aps_cfg_t c;
    int       k;
    i_clock = 1'b0;
    i_clk_en = 1'b1;
    {i_init, i_start, i_stop} = 3'h0;
    i_q_we = 1'b0;
    i_q_addr = 8'h00;
    i_q_data = '0;
    i_ext_pacer_clk_in = 1'b0;
    i_ext_trig_gate_in = 1'b0;
    i_din = 4'h0;
    slow = 1'b0;
    read_en = 1'b1;
    err_count = 0;
    n_tests = 0;
    base = '0;
    base.trig_src = TRIG_COMMAND;
    base.period = 24'h00_0002;
    base.sample_word = 32'h0000_0003;
    base.q_last = 8'h02;
    i_cfg = base;
    rst(8);
    check("idle outputs", {o_running, o_armed, o_overrun, o_conv_start, o_queue_idx}, 0);
    qtab = '{'{2'h1, 9'h003}, '{2'h2, 9'h044}, '{2'h3, 9'h10F}};
    i_q_we = 1'b1;
    for (int i = 0; i < 3; i++) begin
      i_q_addr = QIDX_W'(i);
      i_q_data = qtab[i];
      step(1);
    end
    i_q_we = 1'b0;
    step(1);

    go(base);
    conv_seq('{0, 1, 2, 0}, '{4, 4, 4});
    ctl(3'h4);
    check("o_running", o_running, 1'b0);
    count_conv(20, k);
    check("conversions after init", k, 0);
    fin("rate");

    c = base;
    c.period = 24'h00_0001;
    c.sample_word = 32'h8002_0003;
    go(c);
    conv_seq('{0, 0, 1, 1, 2, 2, 0}, '{2, 2, 2, 2, 2, 2});
    fin("repeat");

    // Zero interval with a slow converter: reads still keep up, so no overrun
    c = base;
    c.pace_mode = PACE_BURST;
    c.period = 24'h00_0014;
    slow = 1'b1;
    go(c);
    conv_seq('{0, 1, 2, 0}, '{1, 1, 38});
    check("o_overrun", o_overrun, 1'b0);
    slow = 1'b0;
    fin("simultaneous burst");

    c.period = 24'h00_00C8;
    c.intra_burst_interval = 9'h01E;
    go(c);
    conv_seq('{0, 1, 2, 0}, '{60, 60, 280});
    fin("spaced burst");

    for (int m = 0; m < 2; m++) begin
      c = base;
      c.trig_src = TRIG_DIGITAL;
      c.trig_mask = 4'h3;
      c.trig_pattern = 4'h1;
      c.trig_on_mismatch = m[0];
      i_din = m[0] ? 4'h5 : 4'h6;
      go(c);
      step(4);
      check("armed state", {o_armed, o_running}, 2'b10);
      // A frozen clock enable must hold the armed state despite the match
      i_clk_en = 1'b0;
      i_din = m[0] ? 4'h4 : 4'hD;
      step(4);
      check("frozen state", {o_armed, o_running}, 2'b10);
      i_clk_en = 1'b1;
      step(4);
      check("armed state", {o_armed, o_running}, 2'b01);
      fin("digital trigger");
    end

    for (int v = 0; v < 4; v++) begin
      c = base;
      c.trig_src = TRIG_EXTERN;
      c.trig_falling = v[0];
      c.hc_variant = v[1];
      pin(1, v[1], v[0]);
      go(c);
      step(4);
      check("armed state", {o_armed, o_running}, 2'b10);
      pin(1, v[1], !v[0]);
      step(4);
      check("armed state", {o_armed, o_running}, 2'b01);
      fin("external trigger");
    end

    for (int v = 0; v < 4; v++) begin
      c = base;
      c.pace_mode = PACE_EXTCLK;
      c.ext_clk_falling = v[0];
      c.hc_variant = v[1];
      pin(0, v[1], v[0]);
      go(c);
      step(4);
      pin(0, v[1], !v[0]);
      count_conv(5, k);
      check("edge conversions", k, 1);
      pin(0, v[1], v[0]);
      count_conv(5, k);
      check("edge conversions", k, 0);
      fin("external clock");
    end

    c = base;
    c.period = 24'h00_0001;
    c.gated = 1'b1;
    i_ext_trig_gate_in = 1'b0;
    go(c);
    count_conv(20, k);
    check("gated conversions", k, 0);
    i_ext_trig_gate_in = 1'b1;
    step(6);
    count_conv(20, k);
    check("gated conversions", k, 10);
    fin("gated");

    c.gated = 1'b0;
    read_en = 1'b0;
    go(c);
    step(12);
    check("overrun state", {o_overrun, o_running}, 2'b10);
    ctl(3'h2);
    check("o_armed", o_armed, 1'b0);
    ctl(3'h1);
    check("o_overrun", o_overrun, 1'b1);
    ctl(3'h4);
    check("o_overrun", o_overrun, 1'b0);
    read_en = 1'b1;
    fin("overrun");

    // Entries beyond the three loaded are unwritten, so only the index is judged
    c.hc_variant = 1'b1;
    c.q_last = 8'hFF;
    go(c);
    repeat (64) wait_conv(k);
    step(1);
    check("o_queue_idx", o_queue_idx, 8'h00);
    ctl(3'h1);
    check("o_running", o_running, 1'b0);
    fin("short queue");
    tally_and_finish();
  end
endmodule

`default_nettype wire
